// [csmc_config.sv]
// Current-sense and misc configuration bank with its timing logic.
// Assumes a PMBus front end presents decoded word commands, synchronous.
// Summary of operation
// - Word read/write at codes d0 and d1
// - Blanking field gives code times 32 ns, rounded up to 4 clocks
// - Hold measurement start until blanking elapses
// - Fault count codes map to 1..15 odd
// - Fault after consecutive event cycles; gap restarts
// - At most one event per switching cycle
// - Method field picks falling or rising slope
// - Range field picks 25, 35, 50 mV
// - Duty never below minimum floor when limit and drive enabled
// - Bit 7 enables minimum duty limit
// - Bit 10 enables gate drive
// - Bit 2 picks open-drain or push-pull good
// - Bit 1 enables external sensor compensation
// - Bit 0 picks external fault temperature source
`timescale 1ns/1ps
module csmc_config #(
  parameter int DUTY_W = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Command port from PMBus front end
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic cmd_ack,
  output logic [15:0] cmd_rdata,
  // Power stage timing
  input wire logic switch_edge,
  input wire logic cycle_start,
  input wire logic overcurrent_event,
  input wire logic undercurrent_event,
  input wire logic [DUTY_W-1:0] period_len,
  input wire logic [DUTY_W-1:0] duty_raw,
  output logic [DUTY_W-1:0] duty_out,
  output logic measure_start,
  output logic current_fault,
  // Sense front end configuration
  output logic slope_fall,
  output logic slope_rise,
  output logic [1:0] adc_range,
  // Power good pin and temperature
  input wire logic power_good_state,
  output logic power_good_output_o,
  output logic power_good_output_oe_n,
  output logic ext_temp_comp,
  output logic temp_fault_ext_sel
);
  import csmc_pkg::*;

  // ==========================================================
  // Register file
  logic [15:0] current_sense_setup;
  logic [15:0] misc_device_setup;
  logic [15:0] next_current_sense_setup;
  logic [15:0] next_misc_device_setup;
  logic [15:0] next_cmd_rdata;
  logic next_cmd_ack;
  logic hit;

  // Decode; unknown codes get no ack so the front end can NACK
  always_comb begin
    next_current_sense_setup = current_sense_setup;
    next_misc_device_setup = misc_device_setup;
    next_cmd_rdata = cmd_rdata;
    hit = (cmd_code == CSMC_CMD_SENSE) || (cmd_code == CSMC_CMD_MISC);
    next_cmd_ack = cmd_valid && hit;
    if (cmd_valid && hit) begin
      if (cmd_write) begin
        if (cmd_code == CSMC_CMD_SENSE) begin
          next_current_sense_setup = cmd_wdata;
        end else begin
          next_misc_device_setup = cmd_wdata;
        end
      end else begin
        next_cmd_rdata = (cmd_code == CSMC_CMD_SENSE) ? current_sense_setup : misc_device_setup;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      current_sense_setup <= CSMC_SENSE_RST;
      misc_device_setup <= CSMC_MISC_RST;
      cmd_rdata <= 16'h0000;
      cmd_ack <= 1'b0;
    end else begin
      current_sense_setup <= next_current_sense_setup;
      misc_device_setup <= next_misc_device_setup;
      cmd_rdata <= next_cmd_rdata;
      cmd_ack <= next_cmd_ack;
    end
  end

  // ==========================================================
  // Blanking timer
  typedef enum logic [1:0] {
    CSMC_B_IDLE = 2'b01,
    CSMC_B_WAIT = 2'b10
  } csmc_blank_t;
  csmc_blank_t blank_state;
  csmc_blank_t next_blank_state;
  logic [9:0] blank_cnt;
  logic [9:0] next_blank_cnt;
  logic [9:0] blank_len;
  logic [4:0] blank_code;
  logic next_measure_start;

  // Codes above the table saturate at the top entry
  always_comb begin
    blank_code = current_sense_setup[CSMC_BLANK_HI:CSMC_BLANK_LO];
    if (blank_code > CSMC_BLANK_MAX) begin
      blank_code = CSMC_BLANK_MAX;
    end
    blank_len = 10'(blank_code * CSMC_BLANK_STEP_CYC);
  end

  // A new edge restarts the wait, so late ringing cannot leak through
  always_comb begin
    next_blank_state = blank_state;
    next_blank_cnt = blank_cnt;
    next_measure_start = 1'b0;
    unique case (blank_state)
      CSMC_B_IDLE: begin
        if (switch_edge) begin
          if (blank_len == 10'h000) begin
            next_measure_start = 1'b1;
          end else begin
            next_blank_cnt = blank_len - 10'h001;
            next_blank_state = CSMC_B_WAIT;
          end
        end
      end
      CSMC_B_WAIT: begin
        if (switch_edge) begin
          next_blank_cnt = (blank_len == 10'h000) ? 10'h000 : blank_len - 10'h001;
        end else if (blank_cnt == 10'h000) begin
          next_measure_start = 1'b1;
          next_blank_state = CSMC_B_IDLE;
        end else begin
          next_blank_cnt = blank_cnt - 10'h001;
        end
      end
      default: begin
        next_blank_state = CSMC_B_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      blank_state <= CSMC_B_IDLE;
      blank_cnt <= 10'h000;
      measure_start <= 1'b0;
    end else begin
      blank_state <= next_blank_state;
      blank_cnt <= next_blank_cnt;
      measure_start <= next_measure_start;
    end
  end

  // ==========================================================
  // Consecutive event fault counter
  logic seen;
  logic next_seen;
  logic [3:0] run_cnt;
  logic [3:0] next_run_cnt;
  logic [3:0] need;
  logic next_current_fault;
  logic ev;

  // Events latch once per cycle; tally at cycle boundary
  always_comb begin
    need = {current_sense_setup[CSMC_FCNT_HI:CSMC_FCNT_LO], 1'b1};
    ev = overcurrent_event || undercurrent_event;
    next_seen = seen;
    next_run_cnt = run_cnt;
    next_current_fault = current_fault;
    if (cycle_start) begin
      next_seen = ev; // event in boundary cycle counts for new cycle
      if (seen) begin
        if ({1'b0, run_cnt} + 5'h01 >= {1'b0, need}) begin // Spare bit: no wrap at 15
          next_current_fault = 1'b1;
          next_run_cnt = need;
        end else begin
          next_run_cnt = run_cnt + 4'h1;
        end
      end else begin
        next_run_cnt = 4'h0;
        next_current_fault = 1'b0;
      end
    end else if (ev) begin
      next_seen = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      seen <= 1'b0;
      run_cnt <= 4'h0;
      current_fault <= 1'b0;
    end else begin
      seen <= next_seen;
      run_cnt <= next_run_cnt;
      current_fault <= next_current_fault;
    end
  end

  // ==========================================================
  // Static configuration outputs
  always_comb begin
    slope_fall = current_sense_setup[CSMC_METH_HI:CSMC_METH_LO] == CSMC_METH_FALL;
    slope_rise = current_sense_setup[CSMC_METH_HI:CSMC_METH_LO] == CSMC_METH_RISE;
    adc_range = current_sense_setup[CSMC_RANGE_HI:CSMC_RANGE_LO];
    ext_temp_comp = misc_device_setup[CSMC_EXTEN_BIT];
    temp_fault_ext_sel = misc_device_setup[CSMC_EXTF_BIT];
  end

  // Power good pin; open-drain only ever pulls low
  always_comb begin
    power_good_output_o = power_good_state;
    if (misc_device_setup[CSMC_PGPP_BIT]) begin
      power_good_output_oe_n = 1'b0;
    end else begin
      power_good_output_oe_n = power_good_state;
    end
  end

  // ==========================================================
  // Duty limiting and drive gate
  csmc_pulse_limit #(
    .WIDTH(DUTY_W)
  ) u_limit (
    .min_enable(misc_device_setup[CSMC_MINEN_BIT]),
    .min_code(misc_device_setup[CSMC_MIND_HI:CSMC_MIND_LO]),
    .drive_enable(misc_device_setup[CSMC_DRV_BIT]),
    .period_len(period_len),
    .duty_raw(duty_raw),
    .duty_out(duty_out)
  );
endmodule

// [csmc_config_properties.sv]
// Checker for the config bank: command answers and config outputs.
// Assumes it is bound onto csmc_config; one clock, sync reset.
`timescale 1ns/1ps
module csmc_config_properties import csmc_pkg::*; #(
  parameter int DUTY_W = 16
) (
  // Ports grouped by kind to keep the checker short
  input wire logic clock, sys_rst, cmd_valid, cmd_write, cmd_ack,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata, cmd_rdata,
  input wire logic switch_edge, cycle_start, overcurrent_event, undercurrent_event,
  input wire logic [DUTY_W-1:0] period_len, duty_raw, duty_out,
  input wire logic measure_start, current_fault, slope_fall, slope_rise,
  input wire logic [1:0] adc_range,
  input wire logic power_good_state, power_good_output_o, power_good_output_oe_n,
  input wire logic ext_temp_comp, temp_fault_ext_sel
);
  // ==========================================================
  // Decoded requests
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic ok_c;
  logic rd_s;
  logic rd_m;
  assign ok_c = cmd_valid && (cmd_code == CSMC_CMD_SENSE || cmd_code == CSMC_CMD_MISC);
  assign rd_s = ok_c && !cmd_write && !cmd_code[0];
  assign rd_m = ok_c && !cmd_write && cmd_code[0];
  // Ack timing, read-back word against the outputs, fault rising only after cycle start
  chk_ack_one_cycle: assert property (ok_c |=> cmd_ack)
    else $error("ack missing");
  chk_no_stray_ack: assert property (!ok_c |=> !cmd_ack)
    else $error("stray ack");
  chk_slope_code: assert property ($past(rd_s) && cmd_ack |->
    slope_fall == (cmd_rdata[3:2] == 2'h1) && slope_rise == (cmd_rdata[3:2] == 2'h2))
    else $error("slope select wrong");
  chk_range_code: assert property ($past(rd_s) && cmd_ack |-> adc_range == cmd_rdata[1:0])
    else $error("range wrong");
  chk_temp_bits: assert property ($past(rd_m) && cmd_ack |->
    ext_temp_comp == cmd_rdata[1] && temp_fault_ext_sel == cmd_rdata[0])
    else $error("temp select wrong");
  chk_drive_gate: assert property ($past(rd_m) && cmd_ack && !cmd_rdata[10] |-> duty_out == '0)
    else $error("drive not gated");
  chk_pg_style: assert property ($past(rd_m) && cmd_ack |->
    power_good_output_oe_n == (cmd_rdata[2] ? 1'b0 : power_good_state))
    else $error("good pin style wrong");
  chk_duty_floor: assert property ($past(rd_m) && cmd_ack && cmd_rdata[10] && cmd_rdata[7] |->
    32'(duty_out) >= (32'(period_len) * 2 * (32'(cmd_rdata[15:11]) + 1)) / 512)
    else $error("duty below floor");
  chk_fault_on_start: assert property ($rose(current_fault) |-> $past(cycle_start))
    else $error("fault off cycle start");
endmodule

// [csmc_config_test.sv]
// Testbench for the config bank, host model on the command port.
// Assumes csmc_pkg and the checker are compiled first.
`timescale 1ns/1ps
module csmc_config_test;
  import csmc_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid, cmd_write, cmd_ack, a, measure_start, current_fault;
  logic switch_edge = 0, cycle_start = 0, overcurrent_event = 0, undercurrent_event = 0;
  logic slope_fall, slope_rise, power_good_state = 1, power_good_output_o;
  logic power_good_output_oe_n, ext_temp_comp, temp_fault_ext_sel;
  logic [1:0] adc_range;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, cmd_rdata, q, duty_out, period_len = 16'h03e8, duty_raw = 16'h0005;
  int n_mismatch = 0;
  int n_tests = 0;
  csmc_config u_csmc_config (.*);
  csmc_host_model u_csmc_host_model (.*);
  initial forever #5 clock = ~clock;
  // ==========================================================
  // Shared helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    u_csmc_host_model.xfer(1'b1, c, d, a, q);
    chk(16'(a), 16'h0001);
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    u_csmc_host_model.xfer(1'b0, c, 16'h0000, a, q);
    chk(16'(a), 16'h0001);
    chk(q, e);
  endtask
  // One switching cycle: optional events, then the cycle marker
  task automatic cyc(input logic e1, input logic e2);
    overcurrent_event = e1;
    step(1);
    overcurrent_event = 0;
    undercurrent_event = e2;
    step(1);
    undercurrent_event = 0;
    cycle_start = 1;
    step(1);
    cycle_start = 0;
    step(1);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rd(CSMC_CMD_SENSE, CSMC_SENSE_RST);
    rd(CSMC_CMD_MISC, CSMC_MISC_RST);
    wr(CSMC_CMD_MISC, 16'ha5c3);
    u_csmc_host_model.xfer(1'b1, 8'hd2, 16'hffff, a, q);
    chk(16'(a), 16'h0000);
    rd(CSMC_CMD_MISC, 16'ha5c3);
    $display("regs done");
  endtask
  task automatic t_blank;
    int n;
    logic [4:0] codes [3] = '{5'h00, 5'h02, 5'h1a};
    foreach (codes[i]) begin
      wr(CSMC_CMD_SENSE, {codes[i], 11'h005});
      switch_edge = 1;
      step(1);
      switch_edge = 0;
      n = 0;
      while (!measure_start && n < 1000) begin
        step(1);
        n++;
      end
      chk(16'(n), 16'(codes[i] * CSMC_BLANK_STEP_CYC));
    end
    // A second edge in mid-wait restarts the full blanking span
    wr(CSMC_CMD_SENSE, {5'h02, 11'h005});
    switch_edge = 1;
    step(1);
    switch_edge = 0;
    step(3);
    switch_edge = 1;
    step(1);
    switch_edge = 0;
    n = 0;
    while (!measure_start && n < 1000) begin
      step(1);
      n++;
    end
    chk(16'(n), 16'(2 * CSMC_BLANK_STEP_CYC));
    $display("blank done");
  endtask
  task automatic t_sense;
    for (int i = 0; i < 3; i++) begin
      wr(CSMC_CMD_SENSE, 16'((i == 2 ? 8 : 4) + i));
      rd(CSMC_CMD_SENSE, 16'((i == 2 ? 8 : 4) + i));
      chk({slope_rise, slope_fall}, i == 2 ? 16'h0002 : 16'h0001);
      chk(16'(adc_range), 16'(i));
    end
    $display("sense done");
  endtask
  task automatic t_fault;
    wr(CSMC_CMD_SENSE, 16'h0105);
    cyc(1, 1);
    cyc(1, 0);
    chk(16'(current_fault), 16'h0000);
    cyc(0, 0);
    cyc(0, 1);
    cyc(1, 0);
    chk(16'(current_fault), 16'h0000);
    cyc(1, 1);
    chk(16'(current_fault), 16'h0001);
    cyc(0, 0);
    chk(16'(current_fault), 16'h0000);
    wr(CSMC_CMD_SENSE, 16'h0005);
    cyc(1, 0);
    chk(16'(current_fault), 16'h0001);
    cyc(0, 0);
    wr(CSMC_CMD_SENSE, 16'h0705);
    repeat (14) cyc(0, 1);
    chk(16'(current_fault), 16'h0000);
    cyc(0, 1);
    chk(16'(current_fault), 16'h0001);
    $display("fault done");
  endtask
  task automatic t_misc;
    wr(CSMC_CMD_MISC, 16'h1c86);
    rd(CSMC_CMD_MISC, 16'h1c86);
    chk(duty_out, 16'h000f);
    chk({power_good_output_oe_n, ext_temp_comp, temp_fault_ext_sel}, 16'h0002);
    duty_raw = 16'h0064;
    step(1);
    chk(duty_out, 16'h0064);
    duty_raw = 16'h0005;
    wr(CSMC_CMD_MISC, 16'h1c01);
    rd(CSMC_CMD_MISC, 16'h1c01);
    chk(duty_out, 16'h0005);
    chk({power_good_output_oe_n, temp_fault_ext_sel}, 16'h0003);
    power_good_state = 0;
    step(1);
    chk(16'(power_good_output_oe_n), 16'h0000);
    chk(16'(power_good_output_o), 16'h0000);
    wr(CSMC_CMD_MISC, 16'h0080);
    rd(CSMC_CMD_MISC, 16'h0080);
    chk(duty_out, 16'h0000);
    $display("misc done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence and watchdog
  initial begin
    step(6);
    sys_rst = 0;
    t_regs;
    t_blank;
    t_sense;
    t_fault;
    t_misc;
    finish_test;
  end
  initial begin
    #100000;
    n_mismatch++;
    finish_test;
  end
endmodule
bind csmc_config csmc_config_properties #(.DUTY_W(DUTY_W)) u_csmc_config_properties (.*);

// [csmc_host_model.sv]
// Host model: issues word reads and writes to the config bank.
// Assumes the bank answers one clock after a taken command.
`timescale 1ns/1ps
module csmc_host_model (
  // Answer
  input wire logic clock,
  input wire logic cmd_ack,
  input wire logic [15:0] cmd_rdata,
  // Request
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // ==========================================================
  // One word command; callers keep field codes defined
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic a, output logic [15:0] q);
    @(posedge clock);
    #1;
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code = c;
    cmd_wdata = d;
    @(posedge clock);
    #1;
    a = cmd_ack;
    q = cmd_rdata;
    cmd_valid = 1'b0;
    // Released lines show junk, not the last word
    cmd_code = ~c;
    cmd_wdata = ~d;
  endtask
endmodule

// [csmc_pkg.sv]
// Package for the current-sense and misc configuration bank.
// Assumes a word-wide command port from a PMBus front end.
package csmc_pkg;
  // ==========================================================
  // Command codes
  localparam logic [7:0] CSMC_CMD_SENSE = 8'hd0;
  localparam logic [7:0] CSMC_CMD_MISC = 8'hd1;
  // Reset values (chosen; none documented)
  localparam logic [15:0] CSMC_SENSE_RST = 16'h0001;
  localparam logic [15:0] CSMC_MISC_RST = 16'h0000;
  // ==========================================================
  // Sense setup fields
  localparam int CSMC_BLANK_HI = 15;
  localparam int CSMC_BLANK_LO = 11;
  localparam int CSMC_FCNT_HI = 10;
  localparam int CSMC_FCNT_LO = 8;
  localparam int CSMC_METH_HI = 3;
  localparam int CSMC_METH_LO = 2;
  localparam int CSMC_RANGE_HI = 1;
  localparam int CSMC_RANGE_LO = 0;
  localparam logic [4:0] CSMC_BLANK_MAX = 5'h1a;
  localparam logic [1:0] CSMC_METH_FALL = 2'h1;
  localparam logic [1:0] CSMC_METH_RISE = 2'h2;
  // Misc setup fields
  localparam int CSMC_MIND_HI = 15;
  localparam int CSMC_MIND_LO = 11;
  localparam int CSMC_DRV_BIT = 10;
  localparam int CSMC_MINEN_BIT = 7;
  localparam int CSMC_PGPP_BIT = 2;
  localparam int CSMC_EXTEN_BIT = 1;
  localparam int CSMC_EXTF_BIT = 0;
  // ==========================================================
  // Timing
  localparam int CSMC_CLK_MHZ = 100;
  localparam int CSMC_BLANK_STEP_NS = 32;
  // Cycles per blanking step, rounded up
  localparam int CSMC_BLANK_STEP_CYC = (CSMC_BLANK_STEP_NS * CSMC_CLK_MHZ + 999) / 1000;
  localparam int CSMC_DUTY_DEN = 512;
endpackage

// [csmc_pulse_limit.sv]
// Minimum-duty and gate-enable stage for the modulator output.
// Assumes period counter and raw compare value come from the PWM core.
`timescale 1ns/1ps
module csmc_pulse_limit #(
  parameter int WIDTH = 16
) (
  // Configuration
  input wire logic min_enable,
  input wire logic [4:0] min_code,
  input wire logic drive_enable,
  // Period arithmetic
  input wire logic [WIDTH-1:0] period_len,
  input wire logic [WIDTH-1:0] duty_raw,
  // Result
  output logic [WIDTH-1:0] duty_out
);
  import csmc_pkg::*;
  logic [WIDTH+5:0] prod;
  logic [WIDTH-1:0] floor_len;
  // Floor = 2*(code+1)*period/512; truncation keeps it safe low
  always_comb begin
    // Widen before adding so code 31 does not wrap the multiplier to zero
    prod = (WIDTH+6)'(period_len) * (WIDTH+6)'({({1'b0, min_code} + 6'h01), 1'b0});
    floor_len = WIDTH'(prod / (WIDTH+6)'(CSMC_DUTY_DEN));
    if (!drive_enable) begin
      duty_out = '0;
    end else if (min_enable && duty_raw < floor_len) begin
      duty_out = floor_len;
    end else begin
      duty_out = duty_raw;
    end
  end
endmodule
